// ### verilog/touch_key_consts.vh
// Constants for the touch key detect filter: register map, field positions,
// factory defaults and timing figures. Assumes a 40 MHz MCLK.
`ifndef TOUCH_KEY_CONSTS_VH
`define TOUCH_KEY_CONSTS_VH

// ****************************************************
// Register word indices
// ****************************************************
`define REG_CTRL      4'h0
`define REG_KEYSEL    4'h1
`define REG_SETUP_A   4'h2
`define REG_SETUP_B   4'h3
`define REG_STATUS    4'h4
`define REG_SIGNAL    4'h5
`define REG_RECAL     4'h6
`define REG_DET_LO    4'h7
`define REG_DET_HI    4'h8

// ****************************************************
// Field positions
// ****************************************************
`define CTRL_RUN_BIT   0
`define CTRL_HYST_LSB  2
`define A_NEG_THRESHOLD_SETTING_LSB     0
`define A_POS_THRESHOLD_SETTING_LSB     8
`define A_DOWN_DRIFT_RATE_LSB   16
`define A_UP_DRIFT_RATE_LSB   20
`define A_FAST_CONFIRM_LIMIT_LSB     24
`define B_NORMAL_CONFIRM_LIMIT_LSB     0
`define B_NRD_LSB      8
`define B_PRD_LSB      16
`define ST_DET_BIT     16
`define ST_CAL_BIT     17
`define ST_EN_BIT      18
`define ST_FAST_LSB    20
`define ST_NORM_LSB    24

// ****************************************************
// Reset values
// ****************************************************
`define DEF_NEG_THRESHOLD_SETTING    8'h06
`define DEF_POS_THRESHOLD_SETTING    8'h02
`define DEF_DOWN_DRIFT_RATE  4'ha
`define DEF_UP_DRIFT_RATE  4'h4
`define DEF_NORMAL_CONFIRM_LIMIT    8'h02
`define DEF_FAST_CONFIRM_LIMIT    4'h5
`define DEF_NRD     8'h14
`define DEF_PRD     4'h6
`define DEF_HYST    2'h1
`define THR_OFFSET  9'h004
`define NRD_ILLEGAL 8'hff

// ****************************************************
// Timing
// ****************************************************
`define CLK_KHZ         40000
`define TICK_MS         50
`define DOWN_DRIFT_RATE_STEP_MS  250
`define NRD_STEP_MS     500
`define LUT_STEP_MS     100

`endif

// ### verilog/touch_key_detect_filter.v
// Per-key reference tracking, detect confirmation and auto recalibration
// for a matrix touch sensor, with an Avalon-MM register slave.
// Assumes the burst front end answers each BURST_REQ with one SAMPLE_VALID.
`timescale 1ns/1ps
`include "touch_key_consts.vh"

module touch_key_detect_filter #(
  parameter NUM_KEYS    = 48,
  parameter SIG_W       = 16,
  parameter TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
  input  wire                MCLK,
  input  wire                RST,
  input  wire [3:0]          AVS_ADDRESS,
  input  wire                AVS_READ,
  input  wire                AVS_WRITE,
  input  wire [31:0]         AVS_WRITEDATA,
  output reg  [31:0]         AVS_READDATA,
  output reg                 AVS_WAITREQUEST,
  output reg                 BURST_REQ,
  output reg  [5:0]          BURST_KEY,
  input  wire                SAMPLE_VALID,
  input  wire [SIG_W-1:0]    SAMPLE_VALUE,
  output reg  [NUM_KEYS-1:0] KEY_DETECT
);

  // ****************************************************
  // Local constants
  // ****************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_REQ  = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam ST_NEXT = 2'b11;
  localparam [7:0]  ND_MUL  = `DOWN_DRIFT_RATE_STEP_MS / `TICK_MS;
  localparam [11:0] NRD_MUL = `NRD_STEP_MS / `TICK_MS;
  localparam [9:0]  LUT_MUL = `LUT_STEP_MS / `TICK_MS;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // ****************************************************
  // Lookup tables, in 100 ms units
  // ****************************************************
  function [7:0] up_drift_tenths;
    input [3:0] code;
    begin
      if (code < 4'h2) begin
        up_drift_tenths = 8'h01;
      end else begin
        up_drift_tenths = {3'h0, code, 1'b0} - 8'h02;
      end
    end
  endfunction

  function [7:0] pos_recal_tenths;
    input [3:0] idx;
    begin
      case (idx)
        4'h1:    pos_recal_tenths = 8'h01;
        4'h2:    pos_recal_tenths = 8'h02;
        4'h3:    pos_recal_tenths = 8'h03;
        4'h4:    pos_recal_tenths = 8'h05;
        4'h5:    pos_recal_tenths = 8'h07;
        4'h6:    pos_recal_tenths = 8'h0a;
        4'h7:    pos_recal_tenths = 8'h0f;
        4'h8:    pos_recal_tenths = 8'h14;
        4'h9:    pos_recal_tenths = 8'h1e;
        4'ha:    pos_recal_tenths = 8'h32;
        4'hb:    pos_recal_tenths = 8'h46;
        4'hc:    pos_recal_tenths = 8'h64;
        4'hd:    pos_recal_tenths = 8'h96;
        4'he:    pos_recal_tenths = 8'hc8;
        4'hf:    pos_recal_tenths = 8'hfa;
        default: pos_recal_tenths = 8'h00;
      endcase
    end
  endfunction

  // ****************************************************
  // Per-key setup, written by software
  // ****************************************************
  reg [7:0]  neg_threshold_setting [0:NUM_KEYS-1];
  reg [7:0]  pos_threshold_setting [0:NUM_KEYS-1];
  reg [3:0]  down_drift_rate       [0:NUM_KEYS-1];
  reg [3:0]  up_drift_rate         [0:NUM_KEYS-1];
  reg [3:0]  fast_confirm_limit    [0:NUM_KEYS-1];
  reg [7:0]  normal_confirm_limit  [0:NUM_KEYS-1];
  reg [7:0]  neg_recal_delay       [0:NUM_KEYS-1];
  reg [3:0]  pos_recal_delay       [0:NUM_KEYS-1];

  // Per-key run state
  reg [SIG_W-1:0] ref_q  [0:NUM_KEYS-1];
  reg [SIG_W-1:0] sig_q  [0:NUM_KEYS-1];
  reg [3:0]       fast_q [0:NUM_KEYS-1];
  reg [7:0]       norm_q [0:NUM_KEYS-1];
  reg [7:0]       dcnt_q [0:NUM_KEYS-1];
  reg [11:0]      ncnt_q [0:NUM_KEYS-1];
  reg [9:0]       pcnt_q [0:NUM_KEYS-1];
  reg [NUM_KEYS-1:0] below_q;
  reg [NUM_KEYS-1:0] above_q;
  reg [NUM_KEYS-1:0] ndone_q;
  reg [NUM_KEYS-1:0] cal_q;
  reg [NUM_KEYS-1:0] key_en;
  wire [63:0]        det_wide = {{(64-NUM_KEYS){1'b0}}, KEY_DETECT};

  reg        run_q;
  reg [1:0]  hyst_q;
  reg [5:0]  keysel_q;
  reg        recal_wr_q;
  reg [5:0]  recal_key_q;
  reg [1:0]  state_q;
  reg [5:0]  cur_q;
  reg        rep_q;
  reg [31:0] tick_cnt_q;
  reg        tick_q;
  integer    i;

  // ****************************************************
  // Bus slave: one wait cycle, then the access completes
  // ****************************************************
  wire bus_req  = AVS_READ | AVS_WRITE;
  wire bus_done = AVS_WRITE & ~AVS_WAITREQUEST;
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      `REG_CTRL:    rd_mux = {28'h0, hyst_q, 1'b0, run_q};
      `REG_KEYSEL:  rd_mux = {26'h0, keysel_q};
      `REG_SETUP_A: rd_mux = {4'h0, fast_confirm_limit[keysel_q], up_drift_rate[keysel_q],
                              down_drift_rate[keysel_q], pos_threshold_setting[keysel_q],
                              neg_threshold_setting[keysel_q]};
      `REG_SETUP_B: rd_mux = {12'h0, pos_recal_delay[keysel_q], neg_recal_delay[keysel_q],
                              normal_confirm_limit[keysel_q]};
      `REG_STATUS:  rd_mux = {norm_q[keysel_q], fast_q[keysel_q], 1'b0,
                              key_en[keysel_q], cal_q[keysel_q], KEY_DETECT[keysel_q],
                              ref_q[keysel_q]};
      `REG_SIGNAL:  rd_mux = {16'h0, sig_q[keysel_q]};
      `REG_DET_LO:  rd_mux = det_wide[31:0];
      `REG_DET_HI:  rd_mux = det_wide[63:32];
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge MCLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
      if (bus_req & AVS_WAITREQUEST) begin
        AVS_READDATA <= AVS_READ ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      run_q       <= 1'b0;
      hyst_q      <= `DEF_HYST;
      keysel_q    <= 6'h00;
      recal_wr_q  <= 1'b0;
      recal_key_q <= 6'h00;
      for (i = 0; i < NUM_KEYS; i = i + 1) begin
        neg_threshold_setting[i] <= `DEF_NEG_THRESHOLD_SETTING;
        pos_threshold_setting[i] <= `DEF_POS_THRESHOLD_SETTING;
        down_drift_rate[i]       <= `DEF_DOWN_DRIFT_RATE;
        up_drift_rate[i]         <= `DEF_UP_DRIFT_RATE;
        fast_confirm_limit[i]    <= `DEF_FAST_CONFIRM_LIMIT;
        normal_confirm_limit[i]  <= `DEF_NORMAL_CONFIRM_LIMIT;
        neg_recal_delay[i]       <= `DEF_NRD;
        pos_recal_delay[i]       <= `DEF_PRD;
      end
    end else begin
      recal_wr_q <= bus_done && (AVS_ADDRESS == `REG_RECAL);
      if (bus_done) begin
        case (AVS_ADDRESS)
          `REG_CTRL: begin
            run_q  <= AVS_WRITEDATA[`CTRL_RUN_BIT];
            hyst_q <= AVS_WRITEDATA[`CTRL_HYST_LSB +: 2];
          end
          `REG_KEYSEL: keysel_q <= AVS_WRITEDATA[5:0];
          `REG_SETUP_A: begin
            neg_threshold_setting[keysel_q] <= AVS_WRITEDATA[`A_NEG_THRESHOLD_SETTING_LSB +: 8];
            pos_threshold_setting[keysel_q] <= AVS_WRITEDATA[`A_POS_THRESHOLD_SETTING_LSB +: 8];
            down_drift_rate[keysel_q]       <= AVS_WRITEDATA[`A_DOWN_DRIFT_RATE_LSB +: 4];
            up_drift_rate[keysel_q]         <= AVS_WRITEDATA[`A_UP_DRIFT_RATE_LSB +: 4];
            // Zero is out of range and would hit on every sample, as one does; hold at one
            fast_confirm_limit[keysel_q]    <= (AVS_WRITEDATA[`A_FAST_CONFIRM_LIMIT_LSB +: 4] == 4'h0) ?
                                               4'h1 : AVS_WRITEDATA[`A_FAST_CONFIRM_LIMIT_LSB +: 4];
          end
          `REG_SETUP_B: begin
            normal_confirm_limit[keysel_q] <= AVS_WRITEDATA[`B_NORMAL_CONFIRM_LIMIT_LSB +: 8];
            neg_recal_delay[keysel_q]      <= AVS_WRITEDATA[`B_NRD_LSB +: 8];
            pos_recal_delay[keysel_q]      <= AVS_WRITEDATA[`B_PRD_LSB +: 4];
          end
          `REG_RECAL: recal_key_q <= AVS_WRITEDATA[5:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************************
  // Key enables and next key search
  // ****************************************************
  // Enable bit per key, decoded from its normal confirm limit
  reg [5:0]          nxt;
  integer            idx;
  integer            j;

  always @* begin
    for (j = 0; j < NUM_KEYS; j = j + 1) begin
      key_en[j] = (normal_confirm_limit[j] != 8'h00);
    end
  end

  // Disabled keys are skipped entirely so the scan only visits live keys
  always @* begin
    nxt = cur_q;
    idx = 0;
    for (j = NUM_KEYS - 1; j > 0; j = j - 1) begin
      idx = cur_q + j;
      if (idx >= NUM_KEYS) begin
        idx = idx - NUM_KEYS;
      end
      if (key_en[idx]) begin
        nxt = idx[5:0];
      end
    end
  end

  wire scan_wrap = (nxt <= cur_q);

  // ****************************************************
  // Level compares for the key being sampled
  // ****************************************************
  wire [8:0]  neg_t  = {1'b0, neg_threshold_setting[cur_q]} + `THR_OFFSET;
  wire [8:0]  pos_t  = {1'b0, pos_threshold_setting[cur_q]} + `THR_OFFSET;
  wire [8:0]  hyst_d = neg_t >> (3'd4 - {1'b0, hyst_q});
  wire [16:0] val_w  = {{(17-SIG_W){1'b0}}, SAMPLE_VALUE};
  wire [16:0] ref_w  = {{(17-SIG_W){1'b0}}, ref_q[cur_q]};
  // Levels are derived from the live reference, so they move with it
  wire        blw    = (val_w + {8'h00, neg_t}) <= ref_w;
  wire        abv    = val_w >= (ref_w + {8'h00, pos_t});
  wire        rel    = (val_w + {8'h00, neg_t}) > (ref_w + {8'h00, hyst_d});
  wire        fast_hit = ((fast_q[cur_q] + 4'h1) >= fast_confirm_limit[cur_q]);
  wire        norm_hit = ((norm_q[cur_q] + 8'h01) >= normal_confirm_limit[cur_q]);

  // ****************************************************
  // Recalibration of one key
  // ****************************************************
  task recal;
    input [5:0]       k;
    input [SIG_W-1:0] v;
    begin
      ref_q[k]      <= v;
      fast_q[k]     <= 4'h0;
      norm_q[k]     <= 8'h00;
      ncnt_q[k]     <= 12'h000;
      pcnt_q[k]     <= 10'h000;
      dcnt_q[k]     <= 8'h00;
      KEY_DETECT[k] <= 1'b0;
      below_q[k]    <= 1'b0;
      above_q[k]    <= 1'b0;
    end
  endtask

  // ****************************************************
  // Time base, scan sequencer and per-key filter
  // ****************************************************
  always @(posedge MCLK) begin
    if (RST) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      state_q    <= ST_IDLE;
      cur_q      <= 6'h00;
      rep_q      <= 1'b0;
      BURST_REQ  <= 1'b0;
      BURST_KEY  <= 6'h00;
      KEY_DETECT <= {NUM_KEYS{1'b0}};
      below_q    <= {NUM_KEYS{1'b0}};
      above_q    <= {NUM_KEYS{1'b0}};
      ndone_q    <= {NUM_KEYS{1'b0}};
      // Every key takes its first sample as its reference
      cal_q      <= {NUM_KEYS{1'b1}};
      for (i = 0; i < NUM_KEYS; i = i + 1) begin
        ref_q[i]  <= {SIG_W{1'b0}};
        sig_q[i]  <= {SIG_W{1'b0}};
        fast_q[i] <= 4'h0;
        norm_q[i] <= 8'h00;
        dcnt_q[i] <= 8'h00;
        ncnt_q[i] <= 12'h000;
        pcnt_q[i] <= 10'h000;
      end
    end else begin
      BURST_REQ <= 1'b0;

      // Slow timers, all keys in parallel
      if (tick_q) begin
        for (i = 0; i < NUM_KEYS; i = i + 1) begin
          if (KEY_DETECT[i] && neg_recal_delay[i] != 8'h00 &&
              neg_recal_delay[i] != `NRD_ILLEGAL) begin
            if (ncnt_q[i] + 12'h001 >= {4'h0, neg_recal_delay[i]} * NRD_MUL) begin
              recal(i[5:0], sig_q[i]);
            end else begin
              ncnt_q[i] <= ncnt_q[i] + 12'h001;
            end
          end else if (above_q[i] && pos_recal_delay[i] != 4'h0) begin
            if (pcnt_q[i] + 10'h001 >=
                {2'b00, pos_recal_tenths(pos_recal_delay[i])} * LUT_MUL) begin
              recal(i[5:0], sig_q[i]);
            end else begin
              pcnt_q[i] <= pcnt_q[i] + 10'h001;
            end
          end else if (!KEY_DETECT[i] && !below_q[i] && key_en[i] && !cal_q[i]) begin
            if (sig_q[i] > ref_q[i]) begin
              if (dcnt_q[i] + 8'h01 >= up_drift_tenths(up_drift_rate[i]) * LUT_MUL[7:0]) begin
                ref_q[i]  <= ref_q[i] + 1'b1;
                dcnt_q[i] <= 8'h00;
              end else begin
                dcnt_q[i] <= dcnt_q[i] + 8'h01;
              end
            end else if (sig_q[i] < ref_q[i]) begin
              if (dcnt_q[i] + 8'h01 >= {4'h0, down_drift_rate[i]} * ND_MUL) begin
                ref_q[i]  <= ref_q[i] - 1'b1;
                dcnt_q[i] <= 8'h00;
              end else begin
                dcnt_q[i] <= dcnt_q[i] + 8'h01;
              end
            end else begin
              dcnt_q[i] <= 8'h00;
            end
          end
        end
      end

      case (state_q)
        ST_IDLE: begin
          if (run_q && (|key_en)) begin
            cur_q   <= key_en[cur_q] ? cur_q : nxt;
            ndone_q <= {NUM_KEYS{1'b0}};
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          BURST_REQ <= 1'b1;
          BURST_KEY <= cur_q;
          state_q   <= ST_WAIT;
        end
        ST_WAIT: begin
          if (SAMPLE_VALID) begin
            sig_q[cur_q] <= SAMPLE_VALUE;
            rep_q        <= 1'b0;
            state_q      <= ST_NEXT;
            if (cal_q[cur_q]) begin
              recal(cur_q, SAMPLE_VALUE);
              cal_q[cur_q] <= 1'b0;
            end else begin
              above_q[cur_q] <= abv;
              below_q[cur_q] <= blw;
              if (!abv) begin
                pcnt_q[cur_q] <= 10'h000;
              end
              if (KEY_DETECT[cur_q]) begin
                if (rel) begin
                  KEY_DETECT[cur_q] <= 1'b0;
                  ncnt_q[cur_q]     <= 12'h000;
                  fast_q[cur_q]     <= 4'h0;
                  norm_q[cur_q]     <= 8'h00;
                end
              end else if (blw) begin
                if (fast_hit) begin
                  fast_q[cur_q] <= 4'h0;
                  if (!ndone_q[cur_q]) begin
                    ndone_q[cur_q] <= 1'b1;
                    if (norm_hit) begin
                      KEY_DETECT[cur_q] <= 1'b1;
                      norm_q[cur_q]     <= 8'h00;
                      ncnt_q[cur_q]     <= 12'h000;
                    end else begin
                      norm_q[cur_q] <= norm_q[cur_q] + 8'h01;
                    end
                  end
                end else begin
                  fast_q[cur_q] <= fast_q[cur_q] + 4'h1;
                  rep_q         <= 1'b1;
                end
              end else begin
                fast_q[cur_q] <= 4'h0;
                norm_q[cur_q] <= 8'h00;
              end
            end
          end
        end
        ST_NEXT: begin
          if (!run_q || !(|key_en)) begin
            state_q <= ST_IDLE;
          end else if (rep_q && key_en[cur_q]) begin
            state_q <= ST_REQ;
          end else begin
            cur_q   <= nxt;
            state_q <= ST_REQ;
            if (scan_wrap) begin
              ndone_q <= {NUM_KEYS{1'b0}};
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase

      // A host request placed in the same cycle as a key's own clear still lands
      if (recal_wr_q && recal_key_q < NUM_KEYS) begin
        cal_q[recal_key_q] <= 1'b1;
      end
    end
  end

endmodule // touch_key_detect_filter

// ### bench/tkd_monitor.sv
// Port checker for the touch key detect filter.
// Assumes the front end answers each burst request once.
`timescale 1ns/1ps
module tkd_monitor #(parameter NUM_KEYS = 48) (
  input wire                MCLK,
  input wire                RST,
  input wire                AVS_READ,
  input wire                AVS_WRITE,
  input wire                AVS_WAITREQUEST,
  input wire                BURST_REQ,
  input wire [5:0]          BURST_KEY,
  input wire                SAMPLE_VALID,
  input wire [NUM_KEYS-1:0] KEY_DETECT
);
  // ****************
  // Timing relations
  // ****************
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence answer_s; SAMPLE_VALID; endsequence
  sequence next_req_s; ##[2:3] BURST_REQ; endsequence
  wait_pulse_a:
    assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low too long");
  wait_answer_a:
    assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST) else $error("late");
  burst_pulse_a:
    assert property (BURST_REQ |=> !BURST_REQ [*2]) else $error("burst request too long");
  key_hold_a:
    assert property (!BURST_REQ |-> $stable(BURST_KEY)) else $error("burst key moved");
  key_range_a:
    assert property (BURST_REQ |-> BURST_KEY < NUM_KEYS) else $error("burst key range");
  scan_on_a:
    assert property (answer_s |-> next_req_s) else $error("no burst after sample");
  detect_cause_a:
    assert property (|(KEY_DETECT & ~$past(KEY_DETECT)) |-> $past(SAMPLE_VALID) ||
      $past(SAMPLE_VALID, 2) || $past(SAMPLE_VALID, 3)) else $error("detect without sample");
  reset_quiet_a:
    assert property (disable iff (1'b0) RST |=> KEY_DETECT == '0 && !BURST_REQ &&
      AVS_WAITREQUEST) else $error("reset not quiet");
endmodule // tkd_monitor
bind touch_key_detect_filter tkd_monitor #(.NUM_KEYS(NUM_KEYS)) mon (.MCLK(MCLK), .RST(RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .BURST_REQ(BURST_REQ), .BURST_KEY(BURST_KEY), .SAMPLE_VALID(SAMPLE_VALID),
  .KEY_DETECT(KEY_DETECT));

// ### bench/burst_front_end.sv
// Behavioural burst front end: answers each request after a set delay.
// Assumes one-cycle requests with the key index standing beside them.
`timescale 1ns/1ps
module burst_front_end #(parameter [15:0] BASE = 16'h03e8) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        burst_req,
  input  wire [5:0]  burst_key,
  input  wire        touch_on,
  input  wire [5:0]  touch_key,
  input  wire [15:0] touch_value,
  input  wire [3:0]  delay,
  output reg         sample_valid,
  output reg  [15:0] sample_value,
  output reg  [7:0]  low_count
);
  reg       busy_q;
  reg [3:0] wait_q;
  reg [5:0] key_q;
  // ***************
  // Answer sequence
  // ***************
  // Value toggles outside answers so a late capture never sees a held sample
  always @(posedge mclk) begin
    sample_valid <= 1'b0;
    sample_value <= ~sample_value;
    if (rst) begin
      busy_q       <= 1'b0;
      sample_value <= 16'h0000;
      low_count    <= 8'h00;
    end else if (burst_req) begin
      busy_q <= 1'b1;
      wait_q <= delay;
      key_q  <= burst_key;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q       <= 1'b0;
      sample_valid <= 1'b1;
      sample_value <= BASE;
      if (touch_on && key_q == touch_key) begin
        sample_value <= touch_value;
        low_count    <= low_count + 8'h01;
      end
    end
  end
endmodule // burst_front_end

// ### bench/touch_key_detect_filter_tb.sv
// Self-checking bench for the touch key detect filter over its register bus.
// Assumes the burst front end model and the bound port checker.
`timescale 1ns/1ps
module touch_key_detect_filter_tb;
  reg         mclk;
  reg         rst = 1'b1;
  reg         rreq = 1'b0;
  reg         wreq = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         touch = 1'b0;
  reg  [15:0] tval = 16'h0;
  reg  [3:0]  delay = 4'h0;
  reg         dis_hit = 1'b0;
  reg  [31:0] rd;
  reg  [7:0]  lc0;
  wire [31:0] rdata;
  wire        waitreq, breq, sval;
  wire [5:0]  bkey;
  wire [15:0] svalue;
  wire [47:0] det;
  wire [7:0]  lcnt;
  integer     err_count = 0;
  integer     samples_checked = 0;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  touch_key_detect_filter #(.TICK_CYCLES(20)) uut (.MCLK(mclk), .RST(rst),
    .AVS_ADDRESS(addr), .AVS_READ(rreq), .AVS_WRITE(wreq), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .BURST_REQ(breq), .BURST_KEY(bkey),
    .SAMPLE_VALID(sval), .SAMPLE_VALUE(svalue), .KEY_DETECT(det));
  burst_front_end fe (.mclk(mclk), .rst(rst), .burst_req(breq), .burst_key(bkey),
    .touch_on(touch), .touch_key(6'h05), .touch_value(tval), .delay(delay),
    .sample_valid(sval), .sample_value(svalue), .low_count(lcnt));
  // Key 3 is disabled before scanning starts, so any request for it is wrong
  always @(posedge mclk) if (breq && bkey == 6'h03) dis_hit <= 1'b1;
  // *****
  // Tasks
  // *****
  task stop_test;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wreq <= wr;
      rreq <= !wr;
      n = 0;
      @(posedge mclk);
      while (waitreq !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      rd = rdata;
      wreq <= 1'b0;
      rreq <= 1'b0;
      if (n >= 20) begin
        check({31'h0, waitreq}, 32'h0);
        stop_test;
      end
    end
  endtask
  task wait_det(input e, input integer lim);
    integer n;
    begin
      n = 0;
      while (det[5] !== e && n < lim) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n >= lim) begin
        check({31'h0, det[5]}, {31'h0, e});
        stop_test;
      end
    end
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, 4'h2, 32'h0); check(rd, 32'h054a0206);
    bus(1'b0, 4'h3, 32'h0); check(rd, 32'h00061402);
    bus(1'b0, 4'hc, 32'h0); check(rd, 32'h00000000);
    bus(1'b1, 4'h1, 32'h3);
    bus(1'b1, 4'h3, 32'h00061400);
    bus(1'b1, 4'h1, 32'h5);
    // Slowest down drift keeps the threshold still while the boundary is probed
    bus(1'b1, 4'h2, 32'h054f0206);
    bus(1'b0, 4'h2, 32'h0); check(rd, 32'h054f0206);
    bus(1'b1, 4'h0, 32'h5);
    repeat (400) @(posedge mclk);
    tval <= 16'h03df;
    touch <= 1'b1;
    repeat (600) @(posedge mclk);
    check(det[31:0], 32'h0);
    touch <= 1'b0;
    bus(1'b1, 4'h6, 32'h5);
    repeat (300) @(posedge mclk);
    lc0 = lcnt;
    tval <= 16'h03de;
    touch <= 1'b1;
    wait_det(1'b1, 3000);
    check({24'h0, lcnt - lc0}, 32'h0000000a);
    bus(1'b0, 4'h4, 32'h0); check({29'h0, rd[18:16]}, 32'h00000005);
    bus(1'b0, 4'h7, 32'h0); check(rd, 32'h00000020);
    bus(1'b0, 4'h8, 32'h0); check(rd, 32'h00000000);
    bus(1'b0, 4'h5, 32'h0); check(rd, 32'h000003de);
    touch <= 1'b0;
    wait_det(1'b0, 1000);
    check({31'h0, dis_hit}, 32'h0);
    bus(1'b1, 4'h3, 32'h00060102);
    delay <= 4'h3;
    tval <= 16'h03dd;
    touch <= 1'b1;
    wait_det(1'b1, 3000);
    wait_det(1'b0, 600);
    bus(1'b0, 4'h4, 32'h0); check({16'h0, rd[15:0]}, 32'h000003dd);
    touch <= 1'b0;
    repeat (1200) @(posedge mclk);
    bus(1'b0, 4'h4, 32'h0); check({16'h0, rd[15:0]}, 32'h000003e8);
    stop_test;
  end
endmodule // touch_key_detect_filter_tb
